//--- design/psc_top.sv
// power state control: status, thermal, low power, memory and rtc paths
`timescale 1ns/100ps
// Function
// - three power-source comparator results readable as status
// - each source interrupt gated by own mask
// - thermal comparator and source on; separately disabled
// - standby low puts regulators into low power
// - standby high returns regulators to active
// - low power scaling only on programmed rails
// - io rail decays, governed by decay bit
// - register rewrites apply at once, also during low power
// - memory regulator follows its enable input
// - termination regulator follows termination control
// - memory type select picks 1.2/1.35/1.1 V
// - termination control scales memory rail
// - above undervoltage and 5.4 V pick higher rtc source
// - rtc from 5 V LDO above undervoltage and 5.4 V
// - standby state on falling standby with power good
// - standby scales programmed rails 0 to 5 and 7
module psc_top
	import psc_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// two-wire register bus
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	// power-source comparators
	input wire logic adapter_present_i,
	input wire logic battery_one_low_i,
	input wire logic battery_two_low_i,
	// host and board pins
	input wire logic standby_i,
	input wire logic system_power_good_i,
	input wire logic memory_supply_enable_i,
	input wire logic termination_control_i,
	input wire logic [1:0] memory_type_select_i,
	// supply comparators
	input wire logic main_above_uvlo_i,
	input wire logic backup_above_main_i,
	input wire logic battery_above_5v4_i,
	// interrupt and mode
	output logic irq_o,
	output logic low_power_mode_o,
	output logic standby_state_o,
	// rail control
	output logic [NUM_RAILS-1:0] rail_scale_o,
	output logic io_rail_decay_o,
	output logic memory_supply_en_o,
	output logic termination_en_o,
	output logic [1:0] memory_target_o,
	// thermal and rtc
	output logic thermal_comp_en_o,
	output logic thermal_isrc_en_o,
	output logic rtc_from_backup_o,
	output logic rtc_ldo_from_5v_o
);
	psc_reg_if bus ();

	logic [SY_W-1:0] sy_d;
	logic [SY_W-1:0] sy_q;
	logic [NUM_SRC-1:0] src;
	logic [NUM_SRC-1:0] src_prev_ff, nxt_src_prev;
	logic [NUM_SRC-1:0] pend_ff, nxt_pend;
	logic [NUM_SRC-1:0] mask_ff, nxt_mask;
	logic [1:0] therm_ff, nxt_therm;
	logic stby_prev_ff, nxt_stby_prev;
	logic stby_state_ff, nxt_stby_state;
	logic [REG_DW-1:0] rail_ff [NUM_RAILS];
	logic [NUM_RAILS-1:0] nxt_scale;
	logic nxt_irq, nxt_lpm, nxt_decay, nxt_bkup, nxt_ldo5;
	logic [1:0] nxt_target;
	logic [REG_DW-1:0] rd;
	logic clr_wr;
	// standby and termination idle high; reset must not fake a sleep
	localparam logic [SY_W-1:0] SY_IDLE = (SY_W'(1) << SY_STANDBY) |
		(SY_W'(1) << SY_TERM);

	psc_i2c_slave u_bus (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o),
		.bus(bus.host)
	);

	assign sy_d = {memory_type_select_i, battery_above_5v4_i,
		backup_above_main_i, main_above_uvlo_i, system_power_good_i,
		memory_supply_enable_i, termination_control_i, standby_i,
		battery_two_low_i, battery_one_low_i, adapter_present_i};

	psc_sync #(.W(SY_W), .RST_VAL(SY_IDLE)) u_pin_sync (
		.clk_i(core_clk_i),
		.rst_i(rst_i),
		.d_i(sy_d),
		.q_o(sy_q)
	);

	assign src = sy_q[SY_BAT2:SY_ADAPTER];
	assign clr_wr = bus.wr_stb && bus.addr == POWER_STATUS_ADDR;

	// control, mask and event flags
	always_comb begin
		nxt_src_prev = src;
		nxt_stby_prev = sy_q[SY_STANDBY];
		nxt_mask = mask_ff;
		nxt_therm = therm_ff;
		if (bus.wr_stb && bus.addr == IRQ_MASK_ADDR)
			nxt_mask = bus.wdata[NUM_SRC-1:0];
		if (bus.wr_stb && bus.addr == THERMAL_CTRL_ADDR)
			nxt_therm = bus.wdata[1:0];
		nxt_pend = pend_ff;
		if (clr_wr)
			nxt_pend = pend_ff & ~bus.wdata[PEND_LSB +: NUM_SRC];
		nxt_pend = nxt_pend | (src ^ src_prev_ff);
		// entry on falling standby only with power good
		nxt_stby_state = stby_state_ff;
		if (stby_prev_ff && !sy_q[SY_STANDBY] && sy_q[SY_PG])
			nxt_stby_state = 1'b1;
		else if (sy_q[SY_STANDBY])
			nxt_stby_state = 1'b0;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			src_prev_ff <= '0;
			stby_prev_ff <= 1'b0;
			mask_ff <= IRQ_MASK_RST;
			therm_ff <= THERMAL_CTRL_RST;
			pend_ff <= '0;
			stby_state_ff <= 1'b0;
		end else begin
			src_prev_ff <= nxt_src_prev;
			stby_prev_ff <= nxt_stby_prev;
			mask_ff <= nxt_mask;
			therm_ff <= nxt_therm;
			pend_ff <= nxt_pend;
			stby_state_ff <= nxt_stby_state;
		end
	end

	// rail control registers, one per address in the window
	for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail
		localparam logic [7:0] RADDR = RAIL_BASE_ADDR + 8'(g);
		localparam logic [7:0] RRST =
			(g == IO_RAIL_IDX) ? IO_CTRL_RST : RAIL_CTRL_RST;
		logic [REG_DW-1:0] nxt_rail;
		logic lpm_req;

		// new settings apply from the next cycle, even in low power
		always_comb begin
			nxt_rail = rail_ff[g];
			if (bus.wr_stb && bus.addr == RADDR)
				nxt_rail = bus.wdata;
		end

		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i)
				rail_ff[g] <= RRST;
			else
				rail_ff[g] <= nxt_rail;
		end

		// termination control drives the memory rail
		assign lpm_req = (g == MEM_RAIL_IDX) ? ~sy_q[SY_TERM] :
			~sy_q[SY_STANDBY];
		assign nxt_scale[g] = (g != IO_RAIL_IDX) && lpm_req &&
			rail_ff[g][RAIL_CHANGE_BIT];
	end

	// output stage
	always_comb begin
		// mask bit set blocks that source
		nxt_irq = |(nxt_pend & ~nxt_mask);
		nxt_lpm = ~sy_q[SY_STANDBY];
		// io rail decays instead of scaling
		nxt_decay = nxt_lpm & rail_ff[IO_RAIL_IDX][IO_DECAY_BIT];
		case (sy_q[SY_MSEL +: 2])
			MEMSEL_LOW: nxt_target = MEM_TARGET_1V20;
			MEMSEL_HIGH: nxt_target = MEM_TARGET_1V35;
			default: nxt_target = MEM_TARGET_1V10;
		endcase
		// below 5.4 V bypass to backup cell
		nxt_ldo5 = sy_q[SY_UVLO] & sy_q[SY_5V4];
		nxt_bkup = ~nxt_ldo5 | sy_q[SY_BKUP];
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			low_power_mode_o <= 1'b0;
			standby_state_o <= 1'b0;
			rail_scale_o <= '0;
			io_rail_decay_o <= 1'b0;
			memory_supply_en_o <= 1'b0;
			termination_en_o <= 1'b0;
			memory_target_o <= MEM_TARGET_1V20;
			thermal_comp_en_o <= THERMAL_CTRL_RST[THERM_COMP_BIT];
			thermal_isrc_en_o <= THERMAL_CTRL_RST[THERM_ISRC_BIT];
			rtc_from_backup_o <= 1'b1;
			rtc_ldo_from_5v_o <= 1'b0;
		end else begin
			irq_o <= nxt_irq;
			low_power_mode_o <= nxt_lpm;
			standby_state_o <= nxt_stby_state;
			rail_scale_o <= nxt_scale;
			io_rail_decay_o <= nxt_decay;
			memory_supply_en_o <= sy_q[SY_MEMEN];
			termination_en_o <= sy_q[SY_TERM];
			memory_target_o <= nxt_target;
			thermal_comp_en_o <= nxt_therm[THERM_COMP_BIT];
			thermal_isrc_en_o <= nxt_therm[THERM_ISRC_BIT];
			rtc_from_backup_o <= nxt_bkup;
			rtc_ldo_from_5v_o <= nxt_ldo5;
		end
	end

	// register read mux; unmapped addresses read zero
	always_comb begin
		rd = '0;
		if (bus.addr >= RAIL_BASE_ADDR && bus.addr <= RAIL_LAST_ADDR)
			rd = rail_ff[RAIL_IW'(bus.addr - RAIL_BASE_ADDR)];
		else begin
			case (bus.addr)
				// live source status plus pending flags
				POWER_STATUS_ADDR: rd = REG_DW'({pend_ff, src});
				IRQ_MASK_ADDR: rd = REG_DW'(mask_ff);
				THERMAL_CTRL_ADDR: rd = REG_DW'(therm_ff);
				MODE_STATUS_ADDR: rd = REG_DW'({rtc_from_backup_o,
					rtc_ldo_from_5v_o, memory_target_o, standby_state_o,
					low_power_mode_o});
				default: rd = '0;
			endcase
		end
	end
	assign bus.rdata = rd;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	a_irq_level: assert property (
		irq_o == |(pend_ff & ~mask_ff)) else $error("irq mismatch");
	a_src_event: assert property (
		$changed(src[SY_ADAPTER]) |=> pend_ff[SY_ADAPTER] [*2])
		else $error("adapter event lost");
	a_pend_hold: assert property (
		pend_ff[SY_ADAPTER] && !clr_wr |=> pend_ff[SY_ADAPTER])
		else $error("pending flag dropped");
	a_lpm_entry: assert property (
		!sy_q[SY_STANDBY] |=> low_power_mode_o) else $error("no lpm");
	a_lpm_exit: assert property (
		sy_q[SY_STANDBY] |=> !low_power_mode_o && !standby_state_o)
		else $error("no active return");
	a_stby_enter: assert property (
		$fell(sy_q[SY_STANDBY]) && sy_q[SY_PG] |=> standby_state_o)
		else $error("standby not entered");
	a_rail_gate: assert property (
		!low_power_mode_o && termination_en_o |->
		rail_scale_o == '0) else $error("scaling while active");
	a_io_decay: assert property (
		!rail_scale_o[IO_RAIL_IDX] && (!io_rail_decay_o ||
		low_power_mode_o)) else $error("io rail misuse");
	a_mem_en: assert property (
		memory_supply_en_o == $past(sy_q[SY_MEMEN]))
		else $error("memory enable wrong");
	a_mem_target: assert property (
		sy_q[SY_MSEL +: 2] == MEMSEL_LOW |=>
		memory_target_o == MEM_TARGET_1V20) else $error("bad target");
	a_rtc_low: assert property (
		!sy_q[SY_5V4] |=> rtc_from_backup_o && !rtc_ldo_from_5v_o)
		else $error("rtc not on backup");
	a_therm_wr: assert property (
		bus.wr_stb && bus.addr == THERMAL_CTRL_ADDR |=>
		thermal_isrc_en_o == $past(bus.wdata[THERM_ISRC_BIT]))
		else $error("thermal write lost");
	a_comp_wr: assert property (
		bus.wr_stb && bus.addr == THERMAL_CTRL_ADDR |=>
		thermal_comp_en_o == $past(bus.wdata[THERM_COMP_BIT]))
		else $error("comparator write lost");
	a_irq_hold: assert property (
		irq_o && !clr_wr && !(bus.wr_stb && bus.addr == IRQ_MASK_ADDR)
		|=> irq_o) else $error("irq dropped while pending");
	a_term_en: assert property (
		!sy_q[SY_TERM] |=> !termination_en_o)
		else $error("termination enable wrong");
	a_mem_scale: assert property (
		!sy_q[SY_TERM] && rail_ff[MEM_RAIL_IDX][RAIL_CHANGE_BIT] |=>
		rail_scale_o[MEM_RAIL_IDX]) else $error("memory rail not scaled");
	a_rtc_high: assert property (
		sy_q[SY_UVLO] && sy_q[SY_5V4] |=> rtc_ldo_from_5v_o &&
		rtc_from_backup_o == $past(sy_q[SY_BKUP]))
		else $error("rtc source wrong");
endmodule : psc_top

//--- pkg/psc_pkg.sv
// shared constants for the power state control block
package psc_pkg;
	localparam int REG_DW = 8;
	localparam int NUM_RAILS = 9;
	localparam int RAIL_IW = 4;
	localparam int MEM_RAIL_IDX = 6;
	localparam int IO_RAIL_IDX = 8;
	localparam logic [7:0] RAIL_BASE_ADDR = 8'h30;
	localparam logic [7:0] RAIL_LAST_ADDR = 8'h38;
	localparam logic [7:0] MEMORY_RAIL_CONTROL_ADDR = 8'h36;
	localparam logic [7:0] POWER_STATUS_ADDR = 8'h40;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h41;
	localparam logic [7:0] THERMAL_CTRL_ADDR = 8'h42;
	localparam logic [7:0] MODE_STATUS_ADDR = 8'h43;
	localparam int RAIL_CHANGE_BIT = 0;
	localparam int IO_DECAY_BIT = 1;
	localparam logic [7:0] RAIL_CTRL_RST = 8'h01;
	localparam logic [7:0] IO_CTRL_RST = 8'h02;
	localparam int NUM_SRC = 3;
	localparam int PEND_LSB = 3;
	localparam logic [2:0] IRQ_MASK_RST = 3'h7;
	localparam int THERM_COMP_BIT = 0;
	localparam int THERM_ISRC_BIT = 1;
	localparam logic [1:0] THERMAL_CTRL_RST = 2'h3;
	localparam int SY_ADAPTER = 0;
	localparam int SY_BAT2 = 2;
	localparam int SY_STANDBY = 3;
	localparam int SY_TERM = 4;
	localparam int SY_MEMEN = 5;
	localparam int SY_PG = 6;
	localparam int SY_UVLO = 7;
	localparam int SY_BKUP = 8;
	localparam int SY_5V4 = 9;
	localparam int SY_MSEL = 10;
	localparam int SY_W = 12;
	localparam logic [1:0] MEMSEL_LOW = 2'h0;
	localparam logic [1:0] MEMSEL_HIGH = 2'h3;
	localparam logic [1:0] MEM_TARGET_1V20 = 2'h0;
	localparam logic [1:0] MEM_TARGET_1V35 = 2'h1;
	localparam logic [1:0] MEM_TARGET_1V10 = 2'h2;
	// arbitrary neutral bus address
	localparam logic [6:0] I2C_DEV_ADDR = 7'h18;
	localparam logic [2:0] BIT_LAST = 3'h7;
endpackage : psc_pkg

//--- pkg/psc_reg_if.sv
// register access path between bus slave and register file
`timescale 1ns/100ps
interface psc_reg_if;
	logic wr_stb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport host(output wr_stb, output addr, output wdata, input rdata);
	modport regs(input wr_stb, input addr, input wdata, output rdata);
endinterface : psc_reg_if

//--- design/psc_sync.sv
// three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/100ps
module psc_sync #(
	parameter int W = 1,
	// idle level of each input, so reset does not fake an edge
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] nxt_q;

	// hold old value while the two stages disagree
	always_comb begin
		nxt_q = (s2_ff & s3_ff) | (q_o & (s2_ff | s3_ff));
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			s1_ff <= d_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			q_o <= nxt_q;
		end
	end
endmodule : psc_sync

//--- design/psc_i2c_slave.sv
// two-wire register bus slave with auto-incrementing register pointer
`timescale 1ns/100ps
module psc_i2c_slave
	import psc_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	// register side
	psc_reg_if.host bus
);
	typedef enum {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
		ST_WDAT, ST_WDAT_ACK, ST_RDAT, ST_RACK, ST_RLOAD
	} psc_i2c_state_t;

	psc_i2c_state_t state_ff, nxt_state;
	logic [1:0] pin_q;
	logic [1:0] prev_ff;
	logic [2:0] cnt_ff, nxt_cnt;
	logic [7:0] sh_ff, nxt_sh;
	logic [7:0] reg_ff, nxt_reg;
	logic [7:0] wdat_ff, nxt_wdat;
	logic rw_ff, nxt_rw;
	logic ack_ff, nxt_ack;
	logic wr_ff, nxt_wr;
	logic nxt_oe_n;
	logic scl, sda, rise, fall, start, stop;
	logic [7:0] byte_in;
	logic ack_st;

	psc_sync #(.W(2)) u_pin_sync (
		.clk_i(core_clk_i),
		.rst_i(rst_i),
		.d_i({sda_i, scl_i}),
		.q_o(pin_q)
	);

	assign scl = pin_q[0];
	assign sda = pin_q[1];
	assign rise = scl & ~prev_ff[0];
	assign fall = ~scl & prev_ff[0];
	assign start = scl & prev_ff[0] & prev_ff[1] & ~sda;
	assign stop = scl & prev_ff[0] & ~prev_ff[1] & sda;
	assign byte_in = {sh_ff[6:0], sda};
	assign bus.wr_stb = wr_ff;
	assign bus.addr = reg_ff;
	assign bus.wdata = wdat_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_reg = reg_ff;
		nxt_wdat = wdat_ff;
		nxt_rw = rw_ff;
		nxt_ack = ack_ff;
		nxt_wr = 1'b0;
		if (start) begin
			nxt_state = ST_ADDR;
			nxt_cnt = '0;
			nxt_ack = 1'b0;
		end else if (stop) begin
			nxt_state = ST_IDLE;
		end else if (rise) begin
			case (state_ff)
				ST_ADDR, ST_REG, ST_WDAT: begin
					nxt_sh = byte_in;
					nxt_cnt = cnt_ff + 3'h1;
					if (cnt_ff == BIT_LAST) begin
						if (state_ff == ST_REG) begin
							nxt_reg = byte_in;
							nxt_state = ST_REG_ACK;
						end else if (state_ff == ST_WDAT) begin
							nxt_wdat = byte_in;
							nxt_wr = 1'b1;
							nxt_state = ST_WDAT_ACK;
						end else if (byte_in[7:1] == I2C_DEV_ADDR) begin
							nxt_rw = byte_in[0];
							nxt_state = ST_ADDR_ACK;
						end else begin
							nxt_state = ST_IDLE;
						end
					end
				end
				ST_RDAT: nxt_cnt = cnt_ff + 3'h1;
				// master not acknowledging ends the read
				ST_RACK: nxt_state = sda ? ST_IDLE : ST_RLOAD;
				default: ;
			endcase
		end else if (fall) begin
			case (state_ff)
				ST_ADDR_ACK, ST_REG_ACK, ST_WDAT_ACK: begin
					nxt_ack = ~ack_ff;
					nxt_cnt = '0;
					if (ack_ff) begin
						if (state_ff == ST_ADDR_ACK && rw_ff) begin
							nxt_sh = bus.rdata;
							nxt_reg = reg_ff + 8'h01;
							nxt_state = ST_RDAT;
						end else if (state_ff == ST_ADDR_ACK) begin
							nxt_state = ST_REG;
						end else begin
							// pointer moves only after the write strobe
							if (state_ff == ST_WDAT_ACK)
								nxt_reg = reg_ff + 8'h01;
							nxt_state = ST_WDAT;
						end
					end
				end
				// last bit stays driven through its whole high phase
				ST_RDAT: begin
					if (cnt_ff == '0)
						nxt_state = ST_RACK;
					else
						nxt_sh = {sh_ff[6:0], 1'b0};
				end
				ST_RLOAD: begin
					nxt_sh = bus.rdata;
					nxt_reg = reg_ff + 8'h01;
					nxt_cnt = '0;
					nxt_state = ST_RDAT;
				end
				default: ;
			endcase
		end
		ack_st = nxt_state == ST_ADDR_ACK || nxt_state == ST_REG_ACK ||
			nxt_state == ST_WDAT_ACK;
		nxt_oe_n = ~((ack_st & nxt_ack) | (nxt_state == ST_RDAT & ~nxt_sh[7]));
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= ST_IDLE;
			prev_ff <= '0;
			cnt_ff <= '0;
			sh_ff <= '0;
			reg_ff <= '0;
			wdat_ff <= '0;
			rw_ff <= 1'b0;
			ack_ff <= 1'b0;
			wr_ff <= 1'b0;
			sda_oe_n_o <= 1'b1;
			sda_o <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			prev_ff <= pin_q;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			reg_ff <= nxt_reg;
			wdat_ff <= nxt_wdat;
			rw_ff <= nxt_rw;
			ack_ff <= nxt_ack;
			wr_ff <= nxt_wr;
			sda_oe_n_o <= nxt_oe_n;
			sda_o <= 1'b0;
		end
	end
endmodule : psc_i2c_slave

//--- tb/psc_ec_model.sv
// embedded controller model: two-wire bus master with open-drain data
`timescale 1ns/100ps
module psc_ec_model
	import psc_pkg::*;
(
	// clock
	input wire logic core_clk_i,
	// bus pins
	output logic scl_o,
	output logic sda_pull_o,
	input wire logic sda_i
);
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask : wt
	// data moves mid-low so the slave never sees it change with scl high
	task automatic bit_io(input logic b, output logic r);
		sda_pull_o = !b;
		wt(6);
		scl_o = 1'b1;
		wt(6);
		r = sda_i;
		wt(6);
		scl_o = 1'b0;
		wt(6);
	endtask : bit_io
	task automatic byte_io(input logic [7:0] d, input logic a_in,
			output logic [7:0] r, output logic a_out);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(a_in, a_out);
	endtask : byte_io
	task automatic start_c();
		sda_pull_o = 1'b0;
		wt(6);
		scl_o = 1'b1;
		wt(6);
		sda_pull_o = 1'b1;
		wt(6);
		scl_o = 1'b0;
		wt(6);
	endtask : start_c
	task automatic stop_c();
		sda_pull_o = 1'b1;
		wt(6);
		scl_o = 1'b1;
		wt(6);
		sda_pull_o = 1'b0;
		wt(6);
	endtask : stop_c
	// settings may be rewritten at any time
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
			output logic ok);
		logic [7:0] r;
		logic k0, k1, k2;
		start_c();
		byte_io({I2C_DEV_ADDR, 1'b0}, 1'b1, r, k0);
		byte_io(a, 1'b1, r, k1);
		byte_io(d, 1'b1, r, k2);
		stop_c();
		ok = !(k0 | k1 | k2);
	endtask : write_reg
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
			output logic ok);
		logic [7:0] r;
		logic k0, k1, k2, k3;
		start_c();
		byte_io({I2C_DEV_ADDR, 1'b0}, 1'b1, r, k0);
		byte_io(a, 1'b1, r, k1);
		start_c();
		byte_io({I2C_DEV_ADDR, 1'b1}, 1'b1, r, k2);
		// last byte is refused with a nack before stop
		byte_io(8'hFF, 1'b1, d, k3);
		stop_c();
		ok = !(k0 | k1 | k2);
	endtask : read_reg
endmodule : psc_ec_model

//--- tb/tb_top.sv
// self-checking bench for the power state control block
`timescale 1ns/100ps
module tb_top
	import psc_pkg::*;
;
	logic core_clk, rst, scl, ec_pull, sda_line, sda_drv, sda_oe_n;
	logic [2:0] src;
	logic standby, pg, mem_en, term, uvlo, bkup, v5v4;
	logic [1:0] msel, target;
	logic irq, low_pwr, sby_state, decay, mem_on, term_on;
	logic th_comp, th_isrc, rtc_bk, rtc_l5;
	logic [NUM_RAILS-1:0] rail;
	int errors = 0;
	int n_tests = 0;
	// wired-and data line with pull-up
	assign sda_line = (ec_pull || (!sda_oe_n && !sda_drv)) ? 1'b0 : 1'b1;
	psc_top i_dut (
		.core_clk_i(core_clk), .rst_i(rst),
		.scl_i(scl), .sda_i(sda_line), .sda_o(sda_drv),
		.sda_oe_n_o(sda_oe_n),
		.adapter_present_i(src[0]), .battery_one_low_i(src[1]),
		.battery_two_low_i(src[2]),
		.standby_i(standby), .system_power_good_i(pg),
		.memory_supply_enable_i(mem_en), .termination_control_i(term),
		.memory_type_select_i(msel),
		.main_above_uvlo_i(uvlo), .backup_above_main_i(bkup),
		.battery_above_5v4_i(v5v4),
		.irq_o(irq), .low_power_mode_o(low_pwr),
		.standby_state_o(sby_state), .rail_scale_o(rail),
		.io_rail_decay_o(decay), .memory_supply_en_o(mem_on),
		.termination_en_o(term_on), .memory_target_o(target),
		.thermal_comp_en_o(th_comp), .thermal_isrc_en_o(th_isrc),
		.rtc_from_backup_o(rtc_bk), .rtc_ldo_from_5v_o(rtc_l5)
	);
	psc_ec_model i_ec (
		.core_clk_i(core_clk), .scl_o(scl), .sda_pull_o(ec_pull),
		.sda_i(sda_line)
	);
	task automatic chk(input string nm, input logic [15:0] seen,
			input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic st(input int n);
		repeat (n) @(negedge core_clk);
	endtask : st
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		i_ec.write_reg(a, d, ok);
		chk("write ack", ok, 1'b1);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic ok;
		i_ec.read_reg(a, d, ok);
		chk("read ack", ok, 1'b1);
	endtask : rd
	task automatic tally_and_finish();
		if (errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// about 20k cycles expected; cut a hang well beyond that
	initial begin : wdog
		#500000;
		errors++;
		tally_and_finish();
	end
	initial begin : main
		logic [7:0] d;
		rst = 1'b1;
		src = 3'h0;
		{standby, pg, mem_en, term} = 4'hD;
		{uvlo, v5v4, bkup} = 3'h6;
		msel = MEMSEL_LOW;
		st(10);
		chk("comp en rst", th_comp, 1'b1);
		chk("isrc en rst", th_isrc, 1'b1);
		rst = 1'b0;
		st(3);
		chk("lpm after rst", low_pwr, 1'b0);
		chk("rails after rst", rail, 9'h000);
		chk("sda released", sda_oe_n, 1'b1);
		chk("sda drive", sda_drv, 1'b0);
		st(5);
		rd(THERMAL_CTRL_ADDR, d);
		chk("thermal reg", d, 8'h03);
		rd(RAIL_BASE_ADDR, d);
		chk("rail reg", d, 8'h01);
		rd(RAIL_LAST_ADDR, d);
		chk("io rail reg", d, 8'h02);
		rd(8'h50, d);
		chk("unmapped", d, 8'h00);
		wr(THERMAL_CTRL_ADDR, 8'h01);
		chk("comp on", th_comp, 1'b1);
		chk("isrc off", th_isrc, 1'b0);
		wr(THERMAL_CTRL_ADDR, 8'h02);
		chk("comp off", th_comp, 1'b0);
		chk("isrc on", th_isrc, 1'b1);
		for (int i = 0; i < 8; i++) begin
			{uvlo, v5v4, bkup} = 3'(i);
			st(8);
			chk("rtc ldo", rtc_l5, uvlo & v5v4);
			chk("rtc backup", rtc_bk, !(uvlo & v5v4) | bkup);
		end
		{uvlo, v5v4, bkup} = 3'h6;
		for (int i = 0; i < 4; i++) begin
			msel = 2'(i);
			st(8);
			chk("target", target, i == 0 ? MEM_TARGET_1V20 :
				i == 3 ? MEM_TARGET_1V35 : MEM_TARGET_1V10);
		end
		rd(MODE_STATUS_ADDR, d);
		chk("mode reg", d, 8'h14);
		mem_en = 1'b1;
		st(8);
		chk("mem on", mem_on, 1'b1);
		chk("term on", term_on, 1'b1);
		term = 1'b0;
		st(2);
		chk("term early", term_on, 1'b1);
		st(6);
		chk("term off", term_on, 1'b0);
		chk("mem kept", mem_on, 1'b1);
		chk("mem scale", rail[MEM_RAIL_IDX], 1'b1);
		term = 1'b1;
		st(8);
		wr(MEMORY_RAIL_CONTROL_ADDR, 8'h00);
		term = 1'b0;
		st(8);
		chk("mem no scale", rail[MEM_RAIL_IDX], 1'b0);
		term = 1'b1;
		mem_en = 1'b0;
		st(8);
		chk("mem off", mem_on, 1'b0);
		standby = 1'b0;
		st(2);
		chk("sync delay", low_pwr, 1'b0);
		st(6);
		chk("enter low", low_pwr, 1'b1);
		chk("sby state", sby_state, 1'b1);
		chk("rails", rail, 9'h0BF);
		chk("io decay", decay, 1'b1);
		standby = 1'b1;
		st(8);
		chk("active", low_pwr, 1'b0);
		chk("sby clear", sby_state, 1'b0);
		chk("rails off", rail, 9'h000);
		chk("no decay", decay, 1'b0);
		wr(RAIL_BASE_ADDR + 8'h01, 8'h00);
		wr(RAIL_LAST_ADDR, 8'h01);
		pg = 1'b0;
		standby = 1'b0;
		st(8);
		chk("enter low pg", low_pwr, 1'b1);
		chk("sby no pg", sby_state, 1'b0);
		chk("rails new", rail, 9'h0BD);
		chk("decay bit", decay, 1'b0);
		{standby, pg} = 2'h3;
		src = 3'h3;
		st(8);
		rd(POWER_STATUS_ADDR, d);
		chk("status", d, 8'h1B);
		chk("masked", irq, 1'b0);
		wr(IRQ_MASK_ADDR, 8'h06);
		st(20);
		chk("pend held", irq, 1'b1);
		wr(POWER_STATUS_ADDR, 8'h38);
		rd(POWER_STATUS_ADDR, d);
		chk("status clr", d, 8'h03);
		for (int k = 0; k < 3; k++) begin
			wr(IRQ_MASK_ADDR, 8'h07 ^ (8'h01 << k));
			for (int j = 0; j < 3; j++) begin
				src[j] = !src[j];
				st(8);
				chk("irq", irq, j == k);
				wr(POWER_STATUS_ADDR, 8'h38);
				chk("irq clr", irq, 1'b0);
			end
		end
		tally_and_finish();
	end
endmodule : tb_top
